//--- sac_pkg.sv
// package: constants and carrier types for the converter control block
package sac_pkg;
  localparam int RES_BITS = 10;
  localparam int BUS_BITS = 8;
  localparam int CYCLES_PER_BIT = 8;
  localparam int CONV_CYCLES = 80;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int DONE_PULSE_NS = 400;
  // longest time, rounded down, at least one cycle
  localparam int DONE_PULSE_CYC_RAW = (DONE_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int DONE_PULSE_CYC = (DONE_PULSE_CYC_RAW < 1) ? 1 : DONE_PULSE_CYC_RAW;
  localparam logic [RES_BITS-1:0] RESULT_RST = 10'h000;
  localparam logic [RES_BITS-1:0] RESULT_ZERO = 10'h000;
  localparam logic [5:0] LOW_PAD = 6'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_CONV} sac_state_t;

  typedef struct packed {
    logic select_n;
    logic write_n;
    logic read_n;
  } sac_bus_in_t;

  typedef struct packed {
    logic [BUS_BITS-1:0] data;
    logic data_oe_n;
    logic done_n;
  } sac_bus_out_t;
endpackage

//--- sac_one_shot.sv
// one-shot: a trigger starts a fixed-length high pulse
`timescale 1ns/10ps
module sac_one_shot import sac_pkg::*; #(
  parameter int LEN = DONE_PULSE_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_trigger,
  output logic o_active
);
  localparam int CW = $clog2(LEN + 1);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (i_trigger) begin
      count_next = CW'(LEN);
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_active = (count_reg != '0);
endmodule

//--- sac_control.sv
// converter control: start, successive approximation, result latch, done flag, byte read
// Functional notes
// - select and write low together set start, clear shift register, approximation, done flag.
// - held in reset while both strobes low; conversion starts after one rises.
// - gated clear of start is ignored while start condition persists.
// - resolve msb first, ten comparisons over eighty clocks, marker tracks progress.
// - marker exit copies ten-bit straight binary result into output latches.
// - falling edge of result_transfer fires one-shot setting done flag, output low.
// - set pulse lasts about 400 ns and overrides a standing clear.
// - select and read low together clear done flag and enable data drivers.
// - first byte result 9..2; second byte bits 1,0 on top, rest zero.
// - negative input at or above positive input yields all-zero code.
`timescale 1ns/10ps
module sac_control import sac_pkg::*; (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire sac_bus_in_t i_bus,
  input wire logic i_comp_above,
  output logic [RES_BITS-1:0] o_trial_code,
  output sac_bus_out_t o_bus
);
  sac_state_t state_reg, state_next;
  logic [RES_BITS-1:0] shift_reg, shift_next;
  logic [RES_BITS-1:0] approximation_register, approx_next;
  logic [RES_BITS-1:0] latch_reg, latch_next;
  logic [2:0] phase_reg, phase_next;
  logic done_reg, done_next;
  logic byte_low_reg, byte_low_next;
  logic read_prev_reg, read_prev_next;
  logic result_transfer, result_transfer_next;
  logic set_pulse;

  wire start_cond = !i_bus.select_n && !i_bus.write_n;
  wire read_cond = !i_bus.select_n && !i_bus.read_n;
  wire transfer_fall = result_transfer && !result_transfer_next;

  // the transfer edge sets the flag itself, so the shot only covers the rest of the 400 ns
  sac_one_shot #(.LEN(DONE_PULSE_CYC - 1)) u_shot (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_trigger(transfer_fall),
    .o_active(set_pulse)
  );

  // current trial: decided bits, bit under test set
  always_comb begin
    o_trial_code = approximation_register | shift_reg;
  end

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    approx_next = approximation_register;
    latch_next = latch_reg;
    phase_next = phase_reg;
    result_transfer_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_cond) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // gated clear of start has no effect while the strobes stay low
        if (!start_cond) begin
          state_next = ST_CONV;
          shift_next = {1'b1, {(RES_BITS-1){1'b0}}};
          phase_next = '0;
        end
      end
      ST_CONV: begin
        phase_next = phase_reg + 3'd1;
        if (phase_reg == 3'(CYCLES_PER_BIT - 1)) begin
          // comparator sampled at end of bit period; msb first
          if (i_comp_above) begin
            approx_next = approximation_register | shift_reg;
          end
          shift_next = shift_reg >> 1;
          if (shift_reg[0]) begin
            // marker leaves the shift register
            state_next = ST_IDLE;
            latch_next = i_comp_above ? (approximation_register | shift_reg) : approximation_register;
            result_transfer_next = 1'b1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (start_cond) begin
      state_next = ST_HOLD;
      shift_next = '0;
      approx_next = RESULT_ZERO;
    end
  end

  // read sequencing: byte advances when a read access ends
  always_comb begin
    read_prev_next = read_cond;
    byte_low_next = byte_low_reg;
    if (start_cond) begin
      byte_low_next = 1'b0;
    end else if (read_prev_reg && !read_cond) begin
      byte_low_next = ~byte_low_reg;
    end
  end

  // set overrides clear, so a standing read still shows the done pulse
  always_comb begin
    done_next = done_reg;
    if (start_cond || read_cond) begin
      done_next = 1'b0;
    end
    if (set_pulse || transfer_fall) begin
      done_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      shift_reg <= '0;
      approximation_register <= RESULT_RST;
      latch_reg <= RESULT_RST;
      phase_reg <= '0;
      done_reg <= 1'b0;
      byte_low_reg <= 1'b0;
      read_prev_reg <= 1'b0;
      result_transfer <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      approximation_register <= approx_next;
      latch_reg <= latch_next;
      phase_reg <= phase_next;
      done_reg <= done_next;
      byte_low_reg <= byte_low_next;
      read_prev_reg <= read_prev_next;
      result_transfer <= result_transfer_next;
    end
  end

  always_comb begin
    o_bus.done_n = ~done_reg;
    o_bus.data_oe_n = ~read_cond;
    o_bus.data = byte_low_reg ? {latch_reg[1:0], LOW_PAD} : latch_reg[9:2];
  end

  // ---- checks ----
  logic [7:0] conv_cnt;
  always_ff @(posedge i_clk) begin
    if (i_reset || state_reg != ST_CONV) begin
      conv_cnt <= '0;
    end else begin
      conv_cnt <= conv_cnt + 8'd1;
    end
  end

  sequence s_start;
    start_cond;
  endsequence
  sequence s_release;
    state_reg == ST_HOLD && !start_cond;
  endsequence

  a_start_clears: assert property (@(posedge i_clk) disable iff (i_reset)
    s_start |=> shift_reg == '0 && approximation_register == '0 && state_reg == ST_HOLD)
    else $error("start did not clear converter");
  a_hold_while_low: assert property (@(posedge i_clk) disable iff (i_reset)
    start_cond [*3] |=> state_reg == ST_HOLD)
    else $error("converter left hold with strobes low");
  a_release_runs: assert property (@(posedge i_clk) disable iff (i_reset)
    s_release |=> state_reg == ST_CONV && shift_reg[RES_BITS-1])
    else $error("conversion did not start after release");
  a_conv_length: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(result_transfer) |-> $past(conv_cnt) == 8'(CONV_CYCLES - 1))
    else $error("conversion not eighty clocks");
  a_result_latched: assert property (@(posedge i_clk) disable iff (i_reset)
    result_transfer |-> latch_reg == approximation_register)
    else $error("result not copied to output latch");
  a_done_after_result_transfer: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(result_transfer) |-> !o_bus.done_n)
    else $error("done flag not raised after transfer");
  a_done_pulse_len: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(result_transfer) && read_cond [*1] ##1 read_cond [*8] |-> !o_bus.done_n)
    else $error("done pulse too short under standing read");
  a_read_enables: assert property (@(posedge i_clk) disable iff (i_reset)
    read_cond && !set_pulse |=> (o_bus.data_oe_n == !read_cond) && (!done_reg || set_pulse || $past(transfer_fall)))
    else $error("read did not clear flag or enable data");
  a_low_byte_pad: assert property (@(posedge i_clk) disable iff (i_reset)
    byte_low_reg |-> o_bus.data[5:0] == LOW_PAD && o_bus.data[7:6] == latch_reg[1:0])
    else $error("low byte layout wrong");
  a_byte_restart: assert property (@(posedge i_clk) disable iff (i_reset)
    s_start |=> !byte_low_reg)
    else $error("start did not restore high byte");
endmodule

//--- sac_host_model.sv
// bus host model: drives the strobes and takes read bytes
`timescale 1ns/10ps
module sac_host_model import sac_pkg::*; (
  input wire logic i_clk,
  input wire sac_bus_out_t i_bus,
  output sac_bus_in_t o_bus
);
  initial o_bus = 3'b111;
  // strobes change only just after a rising edge
  task automatic drive(input logic s, input logic w, input logic r);
    @(posedge i_clk);
    o_bus <= {s, w, r};
  endtask
  task automatic start(input int hold);
    drive(1'b0, 1'b0, 1'b1);
    repeat (hold) @(posedge i_clk);
    o_bus <= 3'b111;
  endtask
  // one high cycle after each read so the byte order can advance
  task automatic read(output logic [BUS_BITS-1:0] d, output logic oe_n);
    drive(1'b0, 1'b1, 1'b0);
    @(posedge i_clk);
    d = i_bus.data;
    oe_n = i_bus.data_oe_n;
    o_bus <= 3'b111;
    @(posedge i_clk);
  endtask
  // free-running wiring: select low, write looped back from done, one forced start
  task automatic free_run(input int loops, output int seen);
    int n;
    seen = 0;
    n = 0;
    drive(1'b0, 1'b0, 1'b1);
    while (seen < loops && n < 200 * loops) begin
      @(posedge i_clk);
      n++;
      // done low while the looped-back write is still high: a fresh result
      if (i_bus.done_n === 1'b0 && o_bus.write_n === 1'b1) begin
        seen++;
      end
      if (seen < loops) begin
        o_bus <= {1'b0, i_bus.done_n, 1'b1};
      end
    end
    o_bus <= 3'b111;
  endtask
endmodule

//--- test_sac_control.sv
// testbench: conversions, wide strobes, byte order, standing read
`timescale 1ns/10ps
module test_sac_control;
  import sac_pkg::*;
  logic i_clk;
  logic i_reset;
  logic i_comp_above;
  logic neg_high;
  logic [RES_BITS-1:0] o_trial_code;
  logic [RES_BITS-1:0] analog;
  sac_bus_in_t host_bus;
  sac_bus_out_t o_bus;
  int bad_count;
  int tests_run;
  sac_control uut (.i_clk(i_clk), .i_reset(i_reset), .i_bus(host_bus), .i_comp_above(i_comp_above),
    .o_trial_code(o_trial_code), .o_bus(o_bus));
  sac_host_model host (.i_clk(i_clk), .i_bus(o_bus), .o_bus(host_bus));
  // ideal comparator; neg_high models the minus input above the plus input
  assign i_comp_above = !neg_high && (analog >= o_trial_code);
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_done(output int n);
    n = 0;
    while (o_bus.done_n !== 1'b0 && n < 300) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      $display("wrong value done_n expected 0 seen 1");
    end
  endtask
  task automatic convert(input logic [9:0] code, input int hold, input logic neg);
    int n;
    logic [7:0] d;
    logic oe;
    logic [9:0] exp;
    analog <= code;
    neg_high <= neg;
    exp = neg ? 10'h000 : code;
    host.start(hold);
    #1;
    check("done_n after start", 16'h0001, o_bus.done_n);
    wait_done(n);
    check("conversion span ok", 16'h0001, {15'h0000, n >= 80 && n <= 90});
    repeat (DONE_PULSE_CYC) @(posedge i_clk);
    host.read(d, oe);
    check("first byte", {8'h00, exp[9:2]}, d);
    check("oe_n on read", 16'h0000, oe);
    check("done_n after read", 16'h0001, o_bus.done_n);
    host.read(d, oe);
    check("second byte", {8'h00, exp[1:0], 6'h00}, d);
  endtask
  // outputs enabled throughout: done must still pulse for DONE_PULSE_CYC cycles, the transfer edge plus the one-shot
  task automatic standing_read(input logic [9:0] code);
    int n;
    int k;
    analog <= code;
    neg_high <= 1'b0;
    host.drive(1'b0, 1'b0, 1'b1);
    host.drive(1'b0, 1'b1, 1'b0);
    wait_done(n);
    k = 0;
    while (o_bus.done_n === 1'b0 && k < 100) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    check("done pulse cycles", 16'(DONE_PULSE_CYC), 16'(k));
    check("standing byte", {8'h00, code[9:2]}, {8'h00, o_bus.data});
    host.drive(1'b1, 1'b1, 1'b1);
  endtask
  // select tied low and write looped back to done: restarts on its own
  task automatic free_running(input logic [9:0] code);
    int seen;
    logic [7:0] d;
    logic oe;
    analog <= code;
    neg_high <= 1'b0;
    host.free_run(2, seen);
    check("free-run conversions", 16'h0002, 16'(seen));
    host.read(d, oe);
    check("free-run first byte", {8'h00, code[9:2]}, {8'h00, d});
    host.read(d, oe);
    check("free-run second byte", {8'h00, code[1:0], 6'h00}, {8'h00, d});
  endtask
  initial begin
    i_reset = 1'b1;
    analog = 10'h000;
    neg_high = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    #1;
    check("idle oe_n", 16'h0001, o_bus.data_oe_n);
    convert(10'h2B5, 1, 1'b0);
    convert(10'h3FF, 20, 1'b0);
    convert(10'h3FF, 1, 1'b1);
    standing_read(10'h155);
    convert(10'h0CA, 1, 1'b0);
    free_running(10'h1E7);
    give_verdict();
  end
endmodule
